//--- hps_pkg.sv
package hps_pkg;

	localparam int unsigned CLK_HZ            = 125_000_000;
	localparam int unsigned TICK_US           = 1;
	localparam int unsigned TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TICK_W            = 7;

	localparam int unsigned DEBOUNCE_MS       = 32;
	localparam int unsigned DEBOUNCE_TICKS    = DEBOUNCE_MS * 1000 / TICK_US;
	localparam int unsigned SEQ_DELAY_US      = 125;
	localparam int unsigned SEQ_DELAY_TICKS   = SEQ_DELAY_US / TICK_US;
	localparam int unsigned SEQ_LONG_MS       = 10;
	localparam int unsigned SEQ_LONG_TICKS    = SEQ_LONG_MS * 1000 / TICK_US;
	localparam int unsigned RESET_DELAY_MS    = 20;
	localparam int unsigned RESET_DELAY_TICKS = RESET_DELAY_MS * 1000 / TICK_US;
	localparam int unsigned HOLD_WINDOW_MS    = 500;
	localparam int unsigned HOLD_WINDOW_TICKS = HOLD_WINDOW_MS * 1000 / TICK_US;
	localparam int unsigned TIMER_W           = 20;

	localparam int unsigned SYNC_W            = 8;
	localparam logic [7:0]  SYNC_RST          = 8'h02;

	typedef enum logic [9:0] {
		ST_OFF      = 10'h0001,
		ST_UP_FIRST = 10'h0002,
		ST_SEQ_DLY  = 10'h0004,
		ST_UP_BOTH  = 10'h0008,
		ST_RST_DLY  = 10'h0010,
		ST_HOLD_WIN = 10'h0020,
		ST_ON       = 10'h0040,
		ST_DN_RST   = 10'h0080,
		ST_DN_WAIT  = 10'h0100,
		ST_DN_DLY   = 10'h0200
	} hps_state_t;

endpackage : hps_pkg

//--- hps_deb_if.sv
`timescale 1ns/100ps
interface hps_deb_if;
	logic active;
	logic tick;
	logic settled;

	modport owner
	(
		output active,
		output tick,
		input  settled
	);
	modport filter
	(
		input  active,
		input  tick,
		output settled
	);
endinterface : hps_deb_if

//--- hps_debounce.sv
`timescale 1ns/100ps
module hps_debounce #(
	parameter int unsigned DEB_TICKS = hps_pkg::DEBOUNCE_TICKS
) (
	input wire logic       sys_clk,
	input wire logic       rstn,
	hps_deb_if.filter      deb
);
	import hps_pkg::*;

	localparam int unsigned CNT_W = $clog2(DEB_TICKS + 1);
	localparam logic [CNT_W-1:0] CNT_END = CNT_W'(DEB_TICKS);

	logic [CNT_W-1:0] cnt;

	// any drop to idle restarts the count
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			cnt <= '0;
		else if (!deb.active)
			cnt <= '0;
		else if (deb.tick && cnt != CNT_END)
			cnt <= cnt + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			deb.settled <= 1'b0;
		else
			deb.settled <= deb.active && (cnt == CNT_END);
	end

endmodule : hps_debounce

//--- hps_sequencer.sv
`timescale 1ns/100ps
module hps_sequencer #(
	parameter int unsigned DEB_TICKS  = hps_pkg::DEBOUNCE_TICKS,
	parameter int unsigned SEQ_TICKS  = hps_pkg::SEQ_DELAY_TICKS,
	parameter int unsigned LONG_TICKS = hps_pkg::SEQ_LONG_TICKS,
	parameter int unsigned RST_TICKS  = hps_pkg::RESET_DELAY_TICKS,
	parameter int unsigned HOLD_TICKS = hps_pkg::HOLD_WINDOW_TICKS
) (
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic power_key_in,
	input  wire logic charger_detect_n,
	input  wire logic power_hold,
	input  wire logic long_delay_sel,
	input  wire logic first_above_upper,
	input  wire logic first_below_lower,
	input  wire logic second_above_upper,
	input  wire logic second_below_lower,
	output logic      first_regulator_en,
	output logic      second_regulator_en,
	output logic      proc_reset_n,
	output logic      key_irq_n,
	output logic      charger_present
);
	import hps_pkg::*;

	localparam logic [TICK_W-1:0]  TICK_END  = TICK_W'(TICK_CYCLES - 1);
	localparam logic [TIMER_W-1:0] T_SEQ     = TIMER_W'(SEQ_TICKS);
	localparam logic [TIMER_W-1:0] T_LONG    = TIMER_W'(LONG_TICKS);
	localparam logic [TIMER_W-1:0] T_RST     = TIMER_W'(RST_TICKS);
	localparam logic [TIMER_W-1:0] T_HOLD    = TIMER_W'(HOLD_TICKS);

	hps_deb_if key_if ();
	hps_deb_if chg_if ();

	logic [SYNC_W-1:0]  sync1;
	logic [SYNC_W-1:0]  sync2;
	logic [TICK_W-1:0]  div;
	logic               tick;
	logic [TIMER_W-1:0] tmr;
	logic               first_good;
	logic               second_good;
	logic               key_seen;
	logic               chg_seen;
	logic               key_boot;
	hps_state_t         state;
	hps_state_t         next_state;

	wire key_s    = sync2[0];
	wire chg_n_s  = sync2[1];
	wire hold_s   = sync2[2];
	wire long_s   = sync2[3];
	wire f_up_s   = sync2[4];
	wire f_lo_s   = sync2[5];
	wire s_up_s   = sync2[6];
	wire s_lo_s   = sync2[7];

	function automatic logic elapsed(input logic [TIMER_W-1:0] t,
		input logic [TIMER_W-1:0] lim);
		elapsed = (t >= lim);
	endfunction : elapsed

	function automatic logic in_boot(input hps_state_t s);
		in_boot = (s == ST_UP_FIRST) || (s == ST_SEQ_DLY) || (s == ST_UP_BOTH)
			|| (s == ST_RST_DLY) || (s == ST_HOLD_WIN);
	endfunction : in_boot

	function automatic logic second_on(input hps_state_t s);
		second_on = (s == ST_UP_BOTH) || (s == ST_RST_DLY) || (s == ST_HOLD_WIN)
			|| (s == ST_ON) || (s == ST_DN_RST);
	endfunction : second_on

	// pins come from outside the clock domain
	// reset value equals the idle key and charger pin levels: no false edge after reset
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1 <= SYNC_RST;
			sync2 <= SYNC_RST;
		end
		else
		begin
			sync1 <= {second_below_lower, second_above_upper, first_below_lower,
				first_above_upper, long_delay_sel, power_hold, charger_detect_n,
				power_key_in};
			sync2 <= sync1;
		end
	end

	// 1 us enable keeps the long timers narrow
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div  <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (div == TICK_END);
			div  <= (div == TICK_END) ? '0 : div + 1'b1;
		end
	end

	assign key_if.active = key_s;
	assign key_if.tick   = tick;
	assign chg_if.active = !chg_n_s;
	assign chg_if.tick   = tick;

	hps_debounce #(.DEB_TICKS(DEB_TICKS)) u_key_deb
	(
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.deb     (key_if.filter)
	);

	hps_debounce #(.DEB_TICKS(DEB_TICKS)) u_chg_deb
	(
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.deb     (chg_if.filter)
	);

	// hysteresis: set at upper, clear at lower, else hold
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			first_good  <= 1'b0;
			second_good <= 1'b0;
		end
		else
		begin
			if (f_lo_s)
				first_good <= 1'b0;
			else if (f_up_s)
				first_good <= 1'b1;
			if (s_lo_s)
				second_good <= 1'b0;
			else if (s_up_s)
				second_good <= 1'b1;
		end
	end

	// edge memory so a held key wakes only once
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			key_seen <= 1'b0;
			chg_seen <= 1'b0;
		end
		else
		begin
			key_seen <= key_if.settled;
			chg_seen <= chg_if.settled;
		end
	end

	wire key_press = key_if.settled && !key_seen;
	wire chg_on    = chg_if.settled;
	// charger left in after power-down wakes nothing until reinserted
	wire chg_rise  = chg_if.settled && !chg_seen;
	// flags stay clear until first good, so uv is judged only once both were up
	wire uv        = !first_good || !second_good;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:
				if (key_press || chg_rise)
					next_state = ST_UP_FIRST;
			ST_UP_FIRST:
				if (first_good)
					next_state = ST_SEQ_DLY;
			ST_SEQ_DLY:
				if (elapsed(tmr, long_s ? T_LONG : T_SEQ))
					next_state = ST_UP_BOTH;
			ST_UP_BOTH:
				if (first_good && second_good)
					next_state = ST_RST_DLY;
			ST_RST_DLY:
				if (uv)
					next_state = ST_DN_RST;
				else if (elapsed(tmr, T_RST))
					next_state = ST_HOLD_WIN;
			ST_HOLD_WIN:
				if (uv)
					next_state = ST_DN_RST;
				else if (hold_s)
					next_state = ST_ON;
				// charger present: expiry is harmless, stay up until it leaves
				else if (elapsed(tmr, T_HOLD))
					next_state = chg_on ? ST_ON : ST_DN_RST;
			ST_ON:
				if (uv)
					next_state = ST_DN_RST;
				else if (!hold_s && !chg_on)
					next_state = ST_DN_RST;
			ST_DN_RST:
				if (elapsed(tmr, T_RST))
					next_state = ST_DN_WAIT;
			ST_DN_WAIT:
				if (!second_good)
					next_state = ST_DN_DLY;
			ST_DN_DLY:
				if (elapsed(tmr, long_s ? T_LONG : T_SEQ))
					next_state = ST_OFF;
			// stray codes fall back to off
			default:
				next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			state <= ST_OFF;
		else
			state <= next_state;
	end

	// timer restarts on every state change
	// saturates so a long stay never wraps into a false expiry
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			tmr <= '0;
		else if (next_state != state)
			tmr <= '0;
		else if (tick && tmr != '1)
			tmr <= tmr + 1'b1;
	end

	// charger boot bypasses the key path
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			key_boot <= 1'b0;
		else if (state == ST_OFF && next_state == ST_UP_FIRST)
			key_boot <= key_press && !chg_rise;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			first_regulator_en  <= 1'b0;
			second_regulator_en <= 1'b0;
			proc_reset_n        <= 1'b0;
		end
		else
		begin
			// driven from next_state so outputs move with the state register
			first_regulator_en  <= (next_state != ST_OFF);
			second_regulator_en <= second_on(next_state);
			proc_reset_n        <= (next_state == ST_HOLD_WIN) || (next_state == ST_ON);
		end
	end

	// interrupt low from key press until the hold window resolves
	// a charger boot never sets it; key_boot low forces it high
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			key_irq_n <= 1'b1;
		else if (state == ST_OFF && key_press && !chg_rise)
			key_irq_n <= 1'b0;
		else if (!key_boot || !in_boot(next_state))
			key_irq_n <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			charger_present <= 1'b0;
		else
			charger_present <= chg_on;
	end

endmodule : hps_sequencer

//--- hps_checker.sv
`timescale 1ns/100ps
module hps_checker #(
	parameter int unsigned RST_TICKS = 6
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic power_hold,
	input wire logic first_above_upper,
	input wire logic first_below_lower,
	input wire logic second_above_upper,
	input wire logic second_below_lower,
	input wire logic first_regulator_en,
	input wire logic second_regulator_en,
	input wire logic proc_reset_n,
	input wire logic key_irq_n,
	input wire logic charger_present
);
	// one tick of slack: the tick phase is free against the cause
	localparam int unsigned MIN_RST = (RST_TICKS - 1) * 125;
	// 32 bits so the full-length reset delay in cycles fits
	logic [31:0] both_cnt;
	logic [31:0] lo_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			both_cnt <= 32'h0000_0000;
		else if (!(first_above_upper && second_above_upper))
			both_cnt <= 32'h0000_0000;
		else
			both_cnt <= both_cnt + 32'h0000_0001;
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			lo_cnt <= 32'h0000_0000;
		else if (proc_reset_n)
			lo_cnt <= 32'h0000_0000;
		else
			lo_cnt <= lo_cnt + 32'h0000_0001;
	end
	AST_KEY_UP: assert property (
		$fell(key_irq_n) |-> first_regulator_en && !$past(first_regulator_en))
		else $error("key interrupt without first enable");
	AST_SEQ_UP: assert property (
		$rose(second_regulator_en) |-> $past(first_above_upper, 120))
		else $error("second enable too early");
	AST_RST_DLY: assert property (
		$rose(proc_reset_n) |-> both_cnt >= MIN_RST)
		else $error("reset released too early");
	AST_HOLD_IRQ: assert property (
		$rose(power_hold) && proc_reset_n |-> ##[1:8] key_irq_n)
		else $error("interrupt kept after hold");
	AST_HOLD_DN: assert property (
		$fell(power_hold) && proc_reset_n && !charger_present |-> ##[1:8] !proc_reset_n)
		else $error("no reset after hold low");
	AST_DN_SECOND: assert property (
		$fell(second_regulator_en) |-> lo_cnt >= MIN_RST)
		else $error("second disabled too early");
	AST_DN_FIRST: assert property (
		$fell(first_regulator_en) |-> !second_regulator_en && $past(second_below_lower, 120))
		else $error("first disabled too early");
	AST_UV: assert property (
		($rose(first_below_lower) || $rose(second_below_lower)) && proc_reset_n
		|-> ##[1:8] !proc_reset_n)
		else $error("no reset on undervoltage");
	AST_CHG_ON: assert property (
		$rose(charger_present) && proc_reset_n |=> proc_reset_n && second_regulator_en)
		else $error("charger while on changed outputs");
	COV_UP: cover property ($rose(proc_reset_n));
	COV_DN: cover property ($fell(second_regulator_en));
	COV_CHG: cover property ($rose(charger_present));
endmodule : hps_checker
bind hps_sequencer hps_checker #(.RST_TICKS(RST_TICKS)) u_hps_checker
(
	.sys_clk             (sys_clk),
	.rstn                (rstn),
	.power_hold          (power_hold),
	.first_above_upper   (first_above_upper),
	.first_below_lower   (first_below_lower),
	.second_above_upper  (second_above_upper),
	.second_below_lower  (second_below_lower),
	.first_regulator_en  (first_regulator_en),
	.second_regulator_en (second_regulator_en),
	.proc_reset_n        (proc_reset_n),
	.key_irq_n           (key_irq_n),
	.charger_present     (charger_present)
);

//--- hps_host_model.sv
`timescale 1ns/100ps
module hps_host_model (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        proc_reset_n,
	input wire logic [15:0] hold_delay,
	input wire logic        release_req,
	output logic            power_hold
);
	logic [15:0] cnt;
	// zero delay means the host never answers the window
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 16'h0000;
			power_hold <= 1'b0;
		end
		else if (!proc_reset_n || release_req)
		begin
			cnt <= 16'h0000;
			power_hold <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 16'h0001;
			if (cnt == hold_delay && hold_delay != 16'h0000)
				power_hold <= 1'b1;
		end
	end
endmodule : hps_host_model

//--- test_hps_sequencer.sv
`timescale 1ns/100ps
module test_hps_sequencer;
	logic sys_clk = 0, rstn = 0, power_key_in = 0, charger_detect_n = 1;
	logic long_delay_sel = 0, uv = 0, release_req = 0, power_hold;
	logic first_above_upper = 0, first_below_lower = 1;
	logic second_above_upper = 0, second_below_lower = 1;
	logic first_regulator_en, second_regulator_en, proc_reset_n, key_irq_n, charger_present;
	logic [15:0] hold_delay = 16'h0064;
	int   err_count = 0, total_checks = 0;
	always #4 sys_clk = ~sys_clk;
	// regulators settle one cycle after their enable
	always @(posedge sys_clk)
	begin
		first_above_upper <= first_regulator_en && !uv;
		first_below_lower <= !first_regulator_en || uv;
		second_above_upper <= second_regulator_en;
		second_below_lower <= !second_regulator_en;
	end
	hps_sequencer #(.DEB_TICKS(4), .SEQ_TICKS(2), .LONG_TICKS(5), .RST_TICKS(6),
		.HOLD_TICKS(20)) u_hps_sequencer (.sys_clk(sys_clk), .rstn(rstn),
		.power_key_in(power_key_in), .charger_detect_n(charger_detect_n),
		.power_hold(power_hold), .long_delay_sel(long_delay_sel),
		.first_above_upper(first_above_upper), .first_below_lower(first_below_lower),
		.second_above_upper(second_above_upper), .second_below_lower(second_below_lower),
		.first_regulator_en(first_regulator_en), .second_regulator_en(second_regulator_en),
		.proc_reset_n(proc_reset_n), .key_irq_n(key_irq_n), .charger_present(charger_present));
	hps_host_model u_hps_host_model (.sys_clk(sys_clk), .rstn(rstn),
		.proc_reset_n(proc_reset_n), .hold_delay(hold_delay), .release_req(release_req),
		.power_hold(power_hold));
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task check(input string nm, input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask : check
	function automatic logic pick(input int s);
		return s == 0 ? first_regulator_en : s == 1 ? second_regulator_en : proc_reset_n;
	endfunction : pick
	// bounded wait on enable or reset output, then judged
	task await(input string nm, input int s, input logic v, input int n);
		repeat (n) if (pick(s) !== v) @(negedge sys_clk);
		check(nm, pick(s), v);
	endtask : await
	task press(input int n);
		@(posedge sys_clk) power_key_in <= 1'b1;
		repeat (n) @(posedge sys_clk);
		power_key_in <= 1'b0;
		@(negedge sys_clk);
	endtask : press
	task test_bounce;
		repeat (4)
		begin
			press(250);
			repeat (60) @(posedge sys_clk);
		end
		check("first_en", first_regulator_en, 1'b0);
		check("irq", key_irq_n, 1'b1);
		$display("test bounce done");
	endtask : test_bounce
	task test_key;
		@(posedge sys_clk) power_key_in <= 1'b1;
		repeat (300) @(negedge sys_clk);
		check("first_en", first_regulator_en, 1'b0);
		await("first_en", 0, 1'b1, 400);
		check("irq", key_irq_n, 1'b0);
		check("second_en", second_regulator_en, 1'b0);
		@(posedge sys_clk) power_key_in <= 1'b0;
		await("rst", 2, 1'b1, 3000);
		check("second_en", second_regulator_en, 1'b1);
		repeat (150) @(negedge sys_clk);
		check("irq", key_irq_n, 1'b1);
		repeat (3000) @(negedge sys_clk);
		check("rst", proc_reset_n, 1'b1);
		press(800);
		check("rst", proc_reset_n, 1'b1);
		check("irq", key_irq_n, 1'b1);
		@(posedge sys_clk) charger_detect_n <= 1'b0;
		repeat (800) @(negedge sys_clk);
		check("chg", charger_present, 1'b1);
		check("rst", proc_reset_n, 1'b1);
		@(posedge sys_clk) charger_detect_n <= 1'b1;
		repeat (800) @(posedge sys_clk);
		release_req <= 1'b1;
		await("rst", 2, 1'b0, 20);
		check("second_en", second_regulator_en, 1'b1);
		await("second_en", 1, 1'b0, 1000);
		await("first_en", 0, 1'b0, 600);
		@(posedge sys_clk) release_req <= 1'b0;
		$display("test key done");
	endtask : test_key
	task test_window;
		hold_delay <= 16'h0000;
		press(800);
		await("rst", 2, 1'b1, 3000);
		await("rst", 2, 1'b0, 3500);
		check("irq", key_irq_n, 1'b1);
		await("first_en", 0, 1'b0, 3000);
		$display("test window done");
	endtask : test_window
	task test_uv;
		hold_delay <= 16'h0064;
		press(800);
		await("rst", 2, 1'b1, 3000);
		repeat (300) @(posedge sys_clk);
		uv <= 1'b1;
		await("rst", 2, 1'b0, 10);
		await("first_en", 0, 1'b0, 3000);
		@(posedge sys_clk) uv <= 1'b0;
		$display("test uv done");
	endtask : test_uv
	task test_charger;
		hold_delay <= 16'h0000;
		long_delay_sel <= 1'b1;
		charger_detect_n <= 1'b0;
		await("first_en", 0, 1'b1, 1500);
		check("irq", key_irq_n, 1'b1);
		repeat (300) @(negedge sys_clk);
		check("second_en", second_regulator_en, 1'b0);
		await("rst", 2, 1'b1, 4000);
		check("irq", key_irq_n, 1'b1);
		repeat (3500) @(negedge sys_clk);
		check("rst", proc_reset_n, 1'b1);
		check("second_en", second_regulator_en, 1'b1);
		@(posedge sys_clk) charger_detect_n <= 1'b1;
		await("rst", 2, 1'b0, 1500);
		await("first_en", 0, 1'b0, 3000);
		@(posedge sys_clk) long_delay_sel <= 1'b0;
		$display("test charger done");
	endtask : test_charger
	initial
	begin
		#600_000;
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(negedge sys_clk);
		check("rst", proc_reset_n, 1'b0);
		test_bounce();
		test_key();
		test_window();
		test_uv();
		test_charger();
		summarize();
	end
endmodule : test_hps_sequencer
